// *** fss_fault_status.sv ***
//==============================================================
// Purpose: Fault, alert and power-good signalling of a converter
// Assumes: All inputs synchronous to clk; shared fault and serial data pins split in three, alerts as oe only
// Notes:   Serial target protocol itself lives outside this block
//==============================================================
`timescale 1ns/10ps
`include "fss_defines.svh"
module fss_fault_status (
  input  wire logic                     clk,
  input  wire logic                     rst,
  // Device enable and converter run
  input  wire logic                     device_enable,
  input  wire logic                     converter_run,
  input  wire logic                     latch_mode,
  input  wire logic                     direction_select,
  // Aux regulator monitors
  input  wire logic                     aux_in_window,
  input  wire logic                     aux_soft_start_done,
  input  wire logic                     aux_overvoltage,
  input  wire logic                     aux_undervoltage,
  // Fault monitors
  input  wire fss_pkg::fss_fault_in_type fault_in,
  input  wire logic                     second_overcurrent,
  input  wire logic                     negative_overcurrent,
  input  wire logic                     phase_on,
  input  wire logic                     cycle_end,
  // Serial target pins and status handshake
  input  wire logic                     serial_clock_in,
  input  wire logic                     serial_data_in,
  input  wire logic                     serial_data_drive_low,
  input  wire logic                     status_ack,
  output logic                          serial_clock_sampled,
  output logic                          serial_data_sampled,
  output logic                          serial_data_out,
  output logic                          serial_data_oe,
  // Shared fault line, open-drain
  input  wire logic                     shared_fault_line_in,
  output logic                          shared_fault_line_out,
  output logic                          shared_fault_line_oe,
  // Open-drain alerts: oe high pulls the pin low
  output logic                          aux_regulator_good_oe,
  output logic                          status_change_alert_oe,
  output logic                          severe_failure_alert_oe,
  // Converter control
  output logic                          pwm_enable,
  output logic                          power_stage_driver_enable,
  output logic                          soft_start_request,
  output logic                          boost_mode,
  output fss_pkg::fss_status_type       status
);

  //============================================================
  // Enable tracking and status clear
  //============================================================
  logic                          run_q;
  logic                          en_q;
  logic                          sdata_q;
  logic                          sclk_q;
  wire                           clear_all;
  wire                           run_rise;
  wire                           run_toggled;

  assign clear_all   = !device_enable;
  assign run_rise    = converter_run && !run_q;
  // Either a run or enable change releases a latched stop
  assign run_toggled = (converter_run != run_q) || (device_enable != en_q);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      run_q   <= 1'b0;
      en_q    <= 1'b0;
      sdata_q <= 1'b1;
      sclk_q  <= 1'b1;
    end else begin
      run_q   <= converter_run;
      en_q    <= device_enable;
      sdata_q <= serial_data_in;
      sclk_q  <= serial_clock_in;
    end
  end

  //============================================================
  // Serial target pins
  //============================================================
  // Target only: clock never driven, data only pulled low
  assign serial_clock_sampled = sclk_q;
  assign serial_data_sampled  = sdata_q;
  assign serial_data_out      = 1'b0;
  assign serial_data_oe       = serial_data_drive_low;

  //============================================================
  // Fault response state machine
  //============================================================
  fss_pkg::fss_state_type          state_q;
  fss_pkg::fss_state_type          state_d;
  logic [`FSS_HICCUP_CNT_W-1:0]    wait_q;
  logic                            hic_seen_q;
  logic                            lat_seen_q;
  logic                            start_q;
  wire                             own_fault;
  wire                             line_low;
  wire                             wait_done;

  assign own_fault = fault_in.hiccup_fault || fault_in.latch_fault;
  assign line_low  = !shared_fault_line_in;
  assign wait_done = (wait_q == `FSS_HICCUP_CNT_W'(`FSS_HICCUP_CYCLES - 1));

  always_comb begin
    state_d = state_q;
    case (state_q)
      fss_pkg::FSS_RUN: begin
        if (line_low || own_fault) begin
          state_d = latch_mode ? fss_pkg::FSS_LATCHED
                               : fss_pkg::FSS_HICCUP_WAIT;
        end
      end
      fss_pkg::FSS_HICCUP_WAIT: begin
        // Retry only once the fault is gone
        if (wait_done && !own_fault) begin
          state_d = fss_pkg::FSS_RUN;
        end
      end
      fss_pkg::FSS_LATCHED: begin
        if (run_toggled && !own_fault) begin
          state_d = fss_pkg::FSS_RUN;
        end
      end
      default: state_d = fss_pkg::FSS_RUN;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= fss_pkg::FSS_RUN;
    end else if (clear_all) begin
      state_q <= fss_pkg::FSS_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // Interval restarts each time it elapses while the fault stays
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_q <= '0;
    end else if (state_q != fss_pkg::FSS_HICCUP_WAIT || wait_done) begin
      wait_q <= '0;
    end else begin
      wait_q <= wait_q + 1'b1;
    end
  end

  // Sticky fault records, held while enabled
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hic_seen_q <= 1'b0;
      lat_seen_q <= 1'b0;
    end else if (clear_all) begin
      hic_seen_q <= 1'b0;
      lat_seen_q <= 1'b0;
    end else begin
      if (fault_in.hiccup_fault) hic_seen_q <= 1'b1;
      if (fault_in.latch_fault) lat_seen_q <= 1'b1;
    end
  end

  // One-cycle soft-start request on run rise or hiccup retry
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      start_q <= 1'b0;
    end else begin
      start_q <= converter_run && device_enable &&
                 (run_rise || (state_q != fss_pkg::FSS_RUN &&
                  state_d == fss_pkg::FSS_RUN));
    end
  end

  //============================================================
  // Shared fault line and converter gating
  //============================================================
  wire running;

  assign shared_fault_line_out = 1'b0;
  assign shared_fault_line_oe  = device_enable && own_fault;

  // Gate is combinational so a peer fault stops PWM at once
  assign running = device_enable && converter_run && !line_low &&
                   !own_fault && state_q == fss_pkg::FSS_RUN;
  assign pwm_enable                = running;
  assign power_stage_driver_enable = running;
  assign soft_start_request        = start_q;
  assign boost_mode                = direction_select;

  //============================================================
  // Aux regulator good
  //============================================================
  wire aux_good;

  assign aux_good = aux_in_window && aux_soft_start_done &&
                    !aux_overvoltage && !aux_undervoltage;
  assign aux_regulator_good_oe = !aux_good;

  //============================================================
  // Severe failure detection
  //============================================================
  wire severe;

  fss_severe_detect u_severe (
    .clk            (clk),
    .rst            (rst),
    .clear          (clear_all),
    .over_current   (second_overcurrent || negative_overcurrent),
    .phase_on       (phase_on),
    .cycle_end      (cycle_end),
    .severe_failure (severe)
  );

  assign severe_failure_alert_oe = severe;

  //============================================================
  // Status word and change alert
  //============================================================
  logic warn_q;
  wire  alert;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      warn_q <= 1'b0;
    end else if (clear_all) begin
      warn_q <= 1'b0;
    end else if (fault_in.warning) begin
      warn_q <= 1'b1;
    end
  end

  assign status.severe_failure    = severe;
  assign status.latched_fault     = lat_seen_q;
  assign status.hiccup_fault      = hic_seen_q;
  assign status.shared_fault_seen = (state_q != fss_pkg::FSS_RUN);
  assign status.aux_overvoltage   = aux_overvoltage;
  assign status.aux_undervoltage  = aux_undervoltage;
  assign status.warning           = warn_q;
  assign status.aux_not_good      = !aux_good;

  fss_alert_latch u_alert (
    .clk        (clk),
    .rst        (rst),
    .status     (status),
    .status_ack (status_ack),
    .alert      (alert)
  );

  assign status_change_alert_oe = alert;

endmodule : fss_fault_status

// *** fss_defines.svh ***
// Purpose: Named constants for the fault and status signalling block
// Assumes: 40 MHz system clock
// Notes:   Times are given in their own unit, counts derived from them
`ifndef FSS_DEFINES_SVH
`define FSS_DEFINES_SVH

`define FSS_CLK_HZ          40000000
`define FSS_HICCUP_MS       500
`define FSS_HICCUP_CYCLES   ((`FSS_CLK_HZ / 1000) * `FSS_HICCUP_MS)
`define FSS_SEVERE_CYCLES   3
`define FSS_STATUS_W        8
`define FSS_HICCUP_CNT_W    25
`define FSS_SEV_CNT_W       2

`endif

// *** fss_pkg.sv ***
// Purpose: Shared types for the fault and status signalling block
// Assumes: Status word layout is fixed by the status_type struct
// Notes:   Constants live in fss_defines.svh
package fss_pkg;

  // One bit per monitored condition; a change of any bit raises the alert
  typedef struct packed {
    logic severe_failure;
    logic latched_fault;
    logic hiccup_fault;
    logic shared_fault_seen;
    logic aux_overvoltage;
    logic aux_undervoltage;
    logic warning;
    logic aux_not_good;
  } fss_status_type;

  // Fault inputs from the analog monitors
  typedef struct packed {
    logic hiccup_fault;
    logic latch_fault;
    logic warning;
  } fss_fault_in_type;

  typedef enum logic [1:0] {
    FSS_RUN,
    FSS_HICCUP_WAIT,
    FSS_LATCHED
  } fss_state_type;

endpackage : fss_pkg

// *** fss_severe_detect.sv ***
// Purpose: Detect persistent second-level or negative overcurrent
// Assumes: cycle_end pulses once per switching cycle
// Notes:   The failure output is sticky until cleared
`timescale 1ns/10ps
`include "fss_defines.svh"
module fss_severe_detect (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic clear,
  input  wire logic over_current,
  input  wire logic phase_on,
  input  wire logic cycle_end,
  output logic      severe_failure
);

  logic [`FSS_SEV_CNT_W-1:0] count_q;
  logic                      seen_on_q;
  logic                      seen_off_q;
  logic                      gap_q;
  logic                      fail_q;
  wire                       full_cycle;
  wire                       hit;

  // Condition held in both on and off intervals, no gap
  assign full_cycle = seen_on_q && seen_off_q && !gap_q;
  assign hit = cycle_end && full_cycle &&
               (count_q == `FSS_SEV_CNT_W'(`FSS_SEVERE_CYCLES - 1));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      seen_on_q  <= 1'b0;
      seen_off_q <= 1'b0;
      gap_q      <= 1'b0;
    end else if (clear || cycle_end) begin
      seen_on_q  <= 1'b0;
      seen_off_q <= 1'b0;
      gap_q      <= 1'b0;
    end else begin
      if (over_current && phase_on) seen_on_q <= 1'b1;
      if (over_current && !phase_on) seen_off_q <= 1'b1;
      if (!over_current) gap_q <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_q <= '0;
      fail_q  <= 1'b0;
    end else if (clear) begin
      count_q <= '0;
      fail_q  <= 1'b0;
    end else if (cycle_end) begin
      if (hit) begin
        fail_q <= 1'b1;
      end
      if (full_cycle && !hit) begin
        count_q <= count_q + 1'b1;
      end else begin
        count_q <= '0;
      end
    end
  end

  assign severe_failure = fail_q;

endmodule : fss_severe_detect

// *** fss_alert_latch.sv ***
// Purpose: Raise the status-change alert on any status bit change
// Assumes: status_ack pulses when the controller has read the status
// Notes:   A change in the ack cycle keeps the alert set
`timescale 1ns/10ps
module fss_alert_latch (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire fss_pkg::fss_status_type status,
  input  wire logic                  status_ack,
  output logic                       alert
);

  fss_pkg::fss_status_type last_q;
  logic                    alert_q;
  wire                     changed;

  assign changed = (status != last_q);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      last_q  <= '0;
      alert_q <= 1'b0;
    end else begin
      last_q <= status;
      // Set wins over the read acknowledge
      if (changed) begin
        alert_q <= 1'b1;
      end else if (status_ack) begin
        alert_q <= 1'b0;
      end
    end
  end

  assign alert = alert_q;

endmodule : fss_alert_latch

// *** fss_fault_status_assertions.sv ***
// Purpose: Concurrent checks on the fault status block ports
// Assumes: One clock domain, asynchronous active-high reset
// Notes:   Bound to every instance of the top module
`timescale 1ns/10ps
module fss_fault_status_checker (
  input wire logic                     clk,
  input wire logic                     rst,
  input wire logic                     device_enable,
  input wire logic                     converter_run,
  input wire logic                     direction_select,
  input wire logic                     aux_in_window,
  input wire logic                     aux_soft_start_done,
  input wire logic                     aux_overvoltage,
  input wire logic                     aux_undervoltage,
  input wire fss_pkg::fss_fault_in_type fault_in,
  input wire logic                     cycle_end,
  input wire logic                     soft_start_request,
  input wire logic                     serial_clock_in,
  input wire logic                     serial_clock_sampled,
  input wire logic                     serial_data_in,
  input wire logic                     serial_data_sampled,
  input wire logic                     status_ack,
  input wire logic                     shared_fault_line_in,
  input wire logic                     shared_fault_line_oe,
  input wire logic                     aux_regulator_good_oe,
  input wire logic                     status_change_alert_oe,
  input wire logic                     severe_failure_alert_oe,
  input wire logic                     pwm_enable,
  input wire logic                     power_stage_driver_enable,
  input wire logic                     boost_mode,
  input wire fss_pkg::fss_status_type  status
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  //==========================================================
  // Aux regulator good and alert
  a_aux_release: assert property (
    !aux_regulator_good_oe |-> aux_in_window && aux_soft_start_done)
    else $error("aux good released outside regulation");
  a_aux_fault_low: assert property (
    aux_overvoltage || aux_undervoltage |-> aux_regulator_good_oe)
    else $error("aux good not pulled low on aux fault");
  a_alert_on_change: assert property (
    $changed(status) |=> status_change_alert_oe)
    else $error("status change raised no alert");
  a_alert_holds: assert property (
    status_change_alert_oe && !status_ack |=> status_change_alert_oe)
    else $error("alert dropped before status read");

  //==========================================================
  // Serial target pins
  a_sclk_sampled: assert property (
    serial_clock_sampled == $past(serial_clock_in))
    else $error("serial clock copy not one cycle behind pin");
  a_sdata_sampled: assert property (
    serial_data_sampled == $past(serial_data_in))
    else $error("serial data copy not one cycle behind pin");

  //==========================================================
  // Fault line, converter control, severe failure
  a_fault_pulls_line: assert property (
    device_enable && (fault_in.hiccup_fault || fault_in.latch_fault)
    |-> shared_fault_line_oe)
    else $error("own fault did not pull shared line");
  a_line_low_stops: assert property (
    !shared_fault_line_in |-> !pwm_enable && !power_stage_driver_enable)
    else $error("converter running with shared line low");
  a_run_low_off: assert property (
    !converter_run |-> !pwm_enable)
    else $error("pwm on while run low");
  a_start_on_run: assert property (
    $rose(converter_run) && device_enable |=> soft_start_request)
    else $error("run rise gave no soft-start request");
  a_boost_follows: assert property (
    boost_mode == direction_select)
    else $error("direction mismatch");
  a_severe_cause: assert property (
    $rose(severe_failure_alert_oe) |-> $past(cycle_end))
    else $error("severe failure raised off a cycle end");
  a_enable_clears: assert property (
    $fell(device_enable) |=> !severe_failure_alert_oe)
    else $error("severe failure kept after disable");
  a_status_cleared: assert property (
    $fell(device_enable) |=> !status.hiccup_fault &&
    !status.latched_fault && !status.warning)
    else $error("fault status kept after disable");

  c_alert: cover property ($rose(status_change_alert_oe));
  c_severe: cover property ($rose(severe_failure_alert_oe));
  c_line: cover property (shared_fault_line_oe ##1 !shared_fault_line_oe);
endmodule : fss_fault_status_checker

bind fss_fault_status fss_fault_status_checker chk_u (.*);

// *** fss_partner_model.sv ***
// Purpose: Microcontroller and paralleled peer beside the block
// Assumes: Shared fault line has a pull-up; peer pulls it on command
// Notes:   Status read is modelled by an ack ACK_LAT+1 cycles after the alert rises
`timescale 1ns/10ps
module fss_partner_model #(
  parameter int ACK_LAT = 3
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic shared_fault_line_oe,
  input  wire logic peer_pull_low,
  input  wire logic status_change_alert_oe,
  input  wire logic ack_enable,
  input  wire logic severe_failure_alert_oe,
  output logic      shared_fault_line_in,
  output logic      status_ack,
  output logic      battery_disconnect
);
  logic [3:0] wait_q;

  // Any party pulling low wins over the pull-up
  assign shared_fault_line_in = ~(shared_fault_line_oe | peer_pull_low);
  assign battery_disconnect = severe_failure_alert_oe;

  // Stalled reads (ack_enable low) leave the alert standing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_q <= 4'h0;
      status_ack <= 1'b0;
    end else begin
      status_ack <= 1'b0;
      if (!status_change_alert_oe || !ack_enable || status_ack) begin
        wait_q <= 4'h0;
      end else if (wait_q == 4'(ACK_LAT)) begin
        wait_q <= 4'h0;
        status_ack <= 1'b1;
      end else begin
        wait_q <= wait_q + 4'h1;
      end
    end
  end
endmodule : fss_partner_model

// *** fss_testbench.sv ***
// Purpose: Self-checking bench for the fault status block
// Assumes: 40 MHz clock; hiccup wait far longer than this run
// Notes:   Expected port values queued by driver, checked at negedge
`timescale 1ns/10ps
`define CHK(g, w) begin tests_run++; if ((g) !== (w)) begin mismatches++; \
  $display("unexpected at %0t: got %b want %b", $time, g, w); end end
module testbench;
  typedef struct {logic [7:0] v; logic [7:0] c;} fss_note_type;
  logic clk, rst, device_enable, converter_run, latch_mode;
  logic direction_select, aux_in_window, aux_soft_start_done;
  logic aux_overvoltage, aux_undervoltage, second_overcurrent;
  logic negative_overcurrent, phase_on, cycle_end, serial_clock_in;
  logic serial_data_in, serial_data_drive_low, status_ack;
  logic serial_clock_sampled, serial_data_sampled, serial_data_out;
  logic serial_data_oe, shared_fault_line_in, shared_fault_line_out;
  logic shared_fault_line_oe, aux_regulator_good_oe, soft_start_request;
  logic status_change_alert_oe, severe_failure_alert_oe, pwm_enable;
  logic power_stage_driver_enable, boost_mode, peer_pull_low, ack_enable;
  fss_pkg::fss_fault_in_type fault_in;
  fss_pkg::fss_status_type   status;
  fss_note_type              notes[$];
  fss_note_type              n;
  logic [31:0]               r;
  logic [7:0]                obs;
  int                        mismatches = 0;
  int                        tests_run = 0;

  fss_fault_status dut_u (.*);
  fss_partner_model peer_u (.*, .battery_disconnect());
  // Data wire has a pull-up; only the target pulls it here
  assign serial_data_in = ~serial_data_oe;
  assign obs = {serial_data_oe, boost_mode, severe_failure_alert_oe,
                status_change_alert_oe, aux_regulator_good_oe,
                shared_fault_line_oe, power_stage_driver_enable, pwm_enable};

  task note(input logic [7:0] v, input logic [7:0] c);
    notes.push_back('{v, c});
    @(posedge clk);
  endtask : note

  task cyc(input int k);
    repeat (k) @(posedge clk);
  endtask : cyc

  task end_sim();
    $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim

  //==========================================================
  // Clock, watchdog, monitor
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    #(5000 * 25);
    mismatches++;
    end_sim();
  end

  always @(negedge clk) begin
    if (notes.size() > 0) begin
      n = notes.pop_front();
      if (n.c[0]) `CHK(obs[0], n.v[0])
      if (n.c[1]) `CHK(obs[1], n.v[1])
      if (n.c[2]) `CHK(obs[2], n.v[2])
      if (n.c[3]) `CHK(obs[3], n.v[3])
      if (n.c[4]) `CHK(obs[4], n.v[4])
      if (n.c[5]) `CHK(obs[5], n.v[5])
      if (n.c[6]) `CHK(obs[6], n.v[6])
      if (n.c[7]) `CHK(obs[7], n.v[7])
    end
  end

  //==========================================================
  // Stimulus
  initial begin
    void'($urandom(41124));
    rst = 1'b1;
    {device_enable, converter_run, aux_in_window, aux_soft_start_done} = 4'hf;
    {latch_mode, direction_select, aux_overvoltage, aux_undervoltage} = 4'h0;
    {second_overcurrent, negative_overcurrent, phase_on, cycle_end} = 4'h0;
    {serial_data_drive_low, peer_pull_low, ack_enable} = 3'h1;
    serial_clock_in = 1'b1;
    fault_in = '0;
    cyc(5);
    rst <= 1'b0;
    cyc(3);
    note(8'h03, 8'h07);
    for (int i = 0; i < 16; i++) begin
      r = $urandom;
      {aux_in_window, aux_soft_start_done, aux_overvoltage,
       aux_undervoltage} <= 4'(i);
      direction_select <= r[0];
      serial_data_drive_low <= r[1];
      serial_clock_in <= r[2];
      note({r[1], r[0], 2'b00, i != 12, 3'b011}, 8'hcf);
    end
    {aux_in_window, aux_soft_start_done, aux_overvoltage,
     aux_undervoltage} <= 4'hc;
    cyc(12);
    note(8'h00, 8'h10);
    // Stall the reader so the alert must stand
    ack_enable <= 1'b0;
    fault_in.warning <= 1'b1;
    cyc(6);
    note(8'h10, 8'h10);
    cyc(8);
    note(8'h10, 8'h10);
    ack_enable <= 1'b1;
    cyc(8);
    note(8'h00, 8'h10);
    // Hiccup: no retry long before the interval runs out
    fault_in.hiccup_fault <= 1'b1;
    note(8'h04, 8'h07);
    fault_in.hiccup_fault <= 1'b0;
    cyc(1000);
    note(8'h00, 8'h07);
    device_enable <= 1'b0;
    note(8'h00, 8'h03);
    device_enable <= 1'b1;
    cyc(4);
    note(8'h03, 8'h03);
    // Latch-off from a peer, restarted by the run input
    latch_mode <= 1'b1;
    peer_pull_low <= 1'b1;
    note(8'h00, 8'h07);
    peer_pull_low <= 1'b0;
    cyc(20);
    note(8'h00, 8'h07);
    converter_run <= 1'b0;
    cyc(2);
    note(8'h00, 8'h03);
    converter_run <= 1'b1;
    cyc(4);
    note(8'h03, 8'h03);
    // Own latch-off, restarted by the enable input
    fault_in.latch_fault <= 1'b1;
    note(8'h04, 8'h07);
    fault_in.latch_fault <= 1'b0;
    cyc(20);
    note(8'h00, 8'h03);
    device_enable <= 1'b0;
    cyc(2);
    device_enable <= 1'b1;
    cyc(4);
    note(8'h03, 8'h03);
    // Severe failure, one kind of overcurrent each pass
    for (int k = 0; k < 2; k++) begin
      for (int c = 0; c < 4; c++) begin
        phase_on <= 1'b1;
        cyc(3);
        phase_on <= 1'b0;
        cyc(3);
        cycle_end <= 1'b1;
        cyc(1);
        cycle_end <= 1'b0;
        if (c > 0) begin
          note({2'b00, c == 3, 5'h00}, 8'h20);
        end else if (k == 0) begin
          second_overcurrent <= 1'b1;
        end else begin
          negative_overcurrent <= 1'b1;
        end
      end
      {second_overcurrent, negative_overcurrent} <= 2'b00;
      device_enable <= 1'b0;
      cyc(2);
      note(8'h00, 8'h20);
      device_enable <= 1'b1;
      cyc(2);
    end
    end_sim();
  end
endmodule : testbench
